/* prw_top.sv */
// Purpose: program space read window between the core and memories
// Assumes: memories return read data the cycle after their strobe
// Notes: apb slave answers with one setup and one access cycle
`timescale 1ns/10ps
`default_nettype none
module prw_top
   import prw_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core request side
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic [15:0] cpu_ea,
   input wire logic [15:0] cpu_wdata,
   input wire logic cpu_is_mov,
   input wire logic rpt_active,
   input wire logic rpt_first,
   input wire logic rpt_last,
   input wire logic rpt_int_exit,
   input wire logic rpt_reentry,
   output logic cpu_busy,
   output logic [15:0] cpu_rdata,
   output logic cpu_rvalid,
   output logic cpu_trap,
   // data ram side
   output logic dram_req,
   output logic dram_we,
   output logic [15:0] dram_addr,
   output logic [15:0] dram_wdata,
   input wire logic [15:0] dram_rdata,
   // program flash side
   output logic pm_rd,
   output logic [22:0] pm_addr,
   input wire logic [23:0] pm_rdata,
   // interrupt
   output logic irq
);
   logic [9:0] rpag_q; // read_page_select
   logic [8:0] wpag_q; // write_page_select
   logic [1:0] stat_q; // sticky events
   logic [1:0] mask_q; // event enables
   logic [22:0] last_q; // last window address
   logic [31:0] prdata_q; // read data latched in setup
   logic pslverr_q; // unmapped address seen in setup
   logic accept; // request taken this cycle
   logic x_pm, x_dram, x_trap, x_upper; // translation results
   logic [22:0] x_addr; // translated program address
   logic [1:0] xtra; // extra cycles for this access
   logic [2:0] ld_cnt; // stall count to load
   logic st_busy, st_done; // stall counter state
   prw_state_t state_q; // request sequencer
   logic src_pm_q, upper_q, rd_q; // access in flight
   logic pm_rd_q, dram_req_q, dram_we_q, trap_q, rvalid_q;
   logic [22:0] pm_addr_q;
   logic [15:0] dram_addr_q, dram_wdata_q, rdata_q;
   logic wr_en, set_trap, set_rdone;
   logic [1:0] ev, clr;
   logic cap_now; // read data stands on the memory bus
   logic fetch_d1_q; // fetch state seen one edge ago

   // address translation
   prw_xlate u_xlate (
      .effective_address(cpu_ea),
      .we(cpu_we),
      .read_page_select(rpag_q),
      .write_page_select(wpag_q),
      .to_pm(x_pm),
      .to_dram(x_dram),
      .trap(x_trap),
      .upper(x_upper),
      .pm_addr(x_addr)
   );

   // one new request per free slot
   assign accept = cpu_req & ~st_busy;
   assign cpu_busy = st_busy;

   // extra cycles of a window read
   always_comb begin
      if (!x_pm) begin
         xtra = PRW_XTRA_RPT_RUN; // plain access costs nothing extra
      end else if (rpt_active) begin
         if (rpt_first | rpt_last | rpt_int_exit | rpt_reentry) begin
            xtra = PRW_XTRA_RPT_EDGE;
         end else begin
            xtra = PRW_XTRA_RPT_RUN;
         end
      end else if (cpu_is_mov) begin
         xtra = PRW_XTRA_MOV;
      end else begin
         xtra = PRW_XTRA_OTHER;
      end
      // one fetch cycle precedes the extra ones
      ld_cnt = {1'b0, xtra} + 3'h1;
   end

   // stall counter, trapped requests never load it
   prw_stall u_stall (
      .mclk(mclk),
      .nrst(nrst),
      .load(accept & ~x_trap),
      .count(ld_cnt),
      .busy(st_busy),
      .done(st_done)
   );

   // sequencer, its fetch and wait states time the read data capture
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q <= PRW_IDLE;
      end else begin
         case (state_q)
            PRW_IDLE: begin
               if (accept & ~x_trap) begin
                  state_q <= PRW_FETCH;
               end
            end
            PRW_FETCH: begin
               state_q <= PRW_WAIT;
            end
            PRW_WAIT: begin
               if (st_done) begin
                  state_q <= PRW_IDLE;
               end
            end
            default: begin
               state_q <= PRW_IDLE;
            end
         endcase
      end
   end

   // memory strobes, one cycle after acceptance
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pm_rd_q <= 1'b0;
         dram_req_q <= 1'b0;
         dram_we_q <= 1'b0;
         trap_q <= 1'b0;
      end else begin
         pm_rd_q <= accept & x_pm; // never for writes
         dram_req_q <= accept & x_dram;
         dram_we_q <= accept & x_dram & cpu_we;
         trap_q <= accept & x_trap;
      end
   end

   // address and write data registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pm_addr_q <= 23'h000000;
         dram_addr_q <= 16'h0000;
         dram_wdata_q <= 16'h0000;
         src_pm_q <= 1'b0;
         upper_q <= 1'b0;
         rd_q <= 1'b0;
      end else if (accept & ~x_trap) begin
         pm_addr_q <= x_addr;
         dram_addr_q <= cpu_ea;
         dram_wdata_q <= cpu_wdata;
         src_pm_q <= x_pm;
         upper_q <= x_upper;
         rd_q <= ~cpu_we;
      end
   end

   // catch read data the cycle after the strobe
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
      end else if ((state_q == PRW_WAIT) && rd_q && !src_pm_q && cap_now) begin
         rdata_q <= dram_rdata;
      end else if ((state_q == PRW_WAIT) && rd_q && src_pm_q && cap_now) begin
         // upper word carries the phantom byte on top
         rdata_q <= upper_q ? {PRW_PHANTOM, pm_rdata[23:16]} : pm_rdata[15:0];
      end
   end

   // first wait cycle is the data return cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         fetch_d1_q <= 1'b0;
      end else begin
         fetch_d1_q <= (state_q == PRW_FETCH);
      end
   end
   assign cap_now = fetch_d1_q;

   // completion pulse trails the stall by one edge
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= st_done & rd_q;
      end
   end

   assign pm_rd = pm_rd_q;
   assign pm_addr = pm_addr_q;
   assign dram_req = dram_req_q;
   assign dram_we = dram_we_q;
   assign dram_addr = dram_addr_q;
   assign dram_wdata = dram_wdata_q;
   assign cpu_rdata = rdata_q;
   assign cpu_rvalid = rvalid_q;
   assign cpu_trap = trap_q;

   // last window address seen, readable by software
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         last_q <= 23'h000000;
      end else if (pm_rd_q) begin
         last_q <= pm_addr_q;
      end
   end

   // apb write strobe at the access edge
   assign wr_en = psel & penable & pwrite;

   // page select registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rpag_q <= PRW_RPAG_RST;
         wpag_q <= PRW_WPAG_RST;
      end else if (wr_en) begin
         if (paddr == PRW_OFS_RPAG) begin
            rpag_q <= pwdata[9:0];
         end
         if (paddr == PRW_OFS_WPAG) begin
            wpag_q <= pwdata[8:0];
         end
      end
   end

   // events and write-one-to-clear, a new event beats the clear
   assign set_trap = trap_q;
   assign set_rdone = rvalid_q & src_pm_q;
   assign ev = {set_rdone, set_trap};
   assign clr = (wr_en && paddr == PRW_OFS_STAT) ? pwdata[1:0] : 2'h0;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         stat_q <= PRW_STAT_RST;
      end else begin
         stat_q <= (stat_q & ~clr) | ev;
      end
   end

   // interrupt mask
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mask_q <= PRW_STAT_RST;
      end else if (wr_en && paddr == PRW_OFS_MASK) begin
         mask_q <= pwdata[1:0];
      end
   end
   assign irq = |(stat_q & mask_q);

   // read data latched in the setup cycle so it comes from a flop
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_q <= 1'b0;
         case (paddr)
            PRW_OFS_RPAG: prdata_q <= {22'h000000, rpag_q};
            PRW_OFS_WPAG: prdata_q <= {23'h000000, wpag_q};
            PRW_OFS_STAT: prdata_q <= {30'h00000000, stat_q};
            PRW_OFS_MASK: prdata_q <= {30'h00000000, mask_q};
            PRW_OFS_LAST: prdata_q <= {st_busy, 8'h00, last_q};
            default: begin
               // unmapped: zero data and an error answer
               prdata_q <= 32'h00000000;
               pslverr_q <= 1'b1;
            end
         endcase
      end
   end
   assign prdata = prdata_q;
   assign pready = psel & penable;
   assign pslverr = pslverr_q & psel & penable;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   trap_page_a: assert property (accept && cpu_ea[15] && !cpu_we && rpag_q == 10'h000 |=> cpu_trap)
      else $error("upper read with page zero did not trap");
   win_route_a: assert property (accept && cpu_ea[15] && rpag_q[9] && !cpu_we |=> pm_rd && !dram_req)
      else $error("window read not sent to program memory");
   pm_addr_a: assert property (accept && x_pm |=> pm_addr == {$past(rpag_q[7:0]), $past(cpu_ea[14:0])})
      else $error("program address built wrongly");
   no_pm_write_a: assert property (accept && cpu_we |=> !pm_rd)
      else $error("write reached program memory");
   half_sel_a: assert property (cap_now && src_pm_q && rd_q |=> cpu_rdata == ($past(upper_q) ? {8'h00, $past(pm_rdata[23:16])} : $past(pm_rdata[15:0])))
      else $error("wrong program word half returned");
   mov_extra_a: assert property (accept && x_pm && !rpt_active && cpu_is_mov |=> !cpu_rvalid [*3] ##1 cpu_rvalid)
      else $error("mov window read not one extra cycle");
   other_extra_a: assert property (accept && x_pm && !rpt_active && !cpu_is_mov |-> ##5 cpu_rvalid)
      else $error("other window read not two extra cycles");
   rpt_edge_a: assert property (accept && x_pm && rpt_active && (rpt_first || rpt_last || rpt_int_exit || rpt_reentry) |-> ##5 cpu_rvalid)
      else $error("repeat edge window read timing wrong");
   rpt_run_a: assert property (accept && x_pm && rpt_active && !(rpt_first || rpt_last || rpt_int_exit || rpt_reentry) |-> ##3 cpu_rvalid)
      else $error("steady repeat window read stalled");
   low_ea_a: assert property (accept && !cpu_ea[15] |=> dram_req && dram_addr == $past(cpu_ea))
      else $error("low half access not plain data access");

   win_read_c: cover property (accept && x_pm && x_upper);
   trap_c: cover property (cpu_trap);
   rpt_run_c: cover property (accept && x_pm && rpt_active && !rpt_first && !rpt_last);
endmodule
`default_nettype wire

/* prw_pkg.sv */
// Purpose: shared constants for the program space read window
// Assumes: apb byte addresses, 32-bit data, one word per register
// Notes: page widths follow the page select registers
package prw_pkg;
   // register byte offsets
   localparam logic [7:0] PRW_OFS_RPAG = 8'h00;
   localparam logic [7:0] PRW_OFS_WPAG = 8'h04;
   localparam logic [7:0] PRW_OFS_STAT = 8'h08;
   localparam logic [7:0] PRW_OFS_MASK = 8'h0C;
   localparam logic [7:0] PRW_OFS_LAST = 8'h10;
   // page select widths and reset values
   localparam int PRW_RPAG_W = 10;
   localparam int PRW_WPAG_W = 9;
   localparam logic [9:0] PRW_RPAG_RST = 10'h001;
   localparam logic [8:0] PRW_WPAG_RST = 9'h001;
   // field positions
   localparam int PRW_WIN_BIT = 9;
   localparam int PRW_HALF_BIT = 8;
   localparam int PRW_EA_MSB = 15;
   localparam int PRW_BUSY_BIT = 31;
   // status / mask bit layout
   localparam int PRW_EV_W = 2;
   localparam int PRW_EV_TRAP = 0;
   localparam int PRW_EV_RDONE = 1;
   localparam logic [1:0] PRW_STAT_RST = 2'h0;
   // extra stall cycles for window reads
   localparam logic [1:0] PRW_XTRA_MOV = 2'h1;
   localparam logic [1:0] PRW_XTRA_OTHER = 2'h2;
   localparam logic [1:0] PRW_XTRA_RPT_EDGE = 2'h2;
   localparam logic [1:0] PRW_XTRA_RPT_RUN = 2'h0;
   // upper word has no data in its high byte
   localparam logic [7:0] PRW_PHANTOM = 8'h00;
   // request sequencer states
   typedef enum logic [2:0] {
      PRW_IDLE = 3'b001,
      PRW_FETCH = 3'b010,
      PRW_WAIT = 3'b100
   } prw_state_t;
endpackage

/* prw_xlate.sv */
// Purpose: map a data effective address onto data or program space
// Assumes: purely combinational, evaluated in the request cycle
// Notes: only reads may reach program memory
`timescale 1ns/10ps
`default_nettype none
module prw_xlate
   import prw_pkg::*;
(
   input wire logic [15:0] effective_address,
   input wire logic we,
   input wire logic [9:0] read_page_select,
   input wire logic [8:0] write_page_select,
   output logic to_pm,
   output logic to_dram,
   output logic trap,
   output logic upper,
   output logic [22:0] pm_addr
);
   logic hi; // upper half of the data map
   logic page_zero; // page of the access direction is 000h
   always_comb begin
      hi = effective_address[PRW_EA_MSB];
      // writes look at the write page, reads at the read page
      page_zero = we ? (write_page_select == 9'h000) : (read_page_select == 10'h000);
      trap = hi & page_zero;
      // window only for reads with page bit 9 set
      to_pm = hi & ~we & read_page_select[PRW_WIN_BIT] & ~trap;
      // low half ignores the page entirely
      to_dram = ~trap & ~to_pm;
      upper = read_page_select[PRW_HALF_BIT];
      // page byte above the 15 offset bits
      pm_addr = {read_page_select[7:0], effective_address[14:0]};
   end
endmodule
`default_nettype wire

/* prw_stall.sv */
// Purpose: counts the cycles an accepted access holds the core
// Assumes: load only while not busy
// Notes: done pulses count cycles after the load edge
`timescale 1ns/10ps
`default_nettype none
module prw_stall (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic load,
   input wire logic [2:0] count,
   output logic busy,
   output logic done
);
   logic [2:0] cnt_q; // cycles left before done
   logic act_q; // an access is in flight
   // countdown, done when it reaches zero
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 3'h0;
         act_q <= 1'b0;
      end else if (load) begin
         cnt_q <= count;
         act_q <= 1'b1;
      end else if (act_q) begin
         if (cnt_q == 3'h0) begin
            act_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - 3'h1;
         end
      end
   end
   assign busy = act_q;
   assign done = act_q & (cnt_q == 3'h0);
endmodule
`default_nettype wire

/* prw_mem_model.sv */
// Purpose: data ram and program flash behind the read window
// Assumes: strobes are one-cycle pulses, data due the following cycle
// Notes: idle data lines toggle every cycle so words stale by an odd number of cycles never match
`timescale 1ns/10ps
`default_nettype none
module prw_mem_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic dram_req,
   input wire logic [15:0] dram_addr,
   input wire logic pm_rd,
   input wire logic [22:0] pm_addr,
   output logic [15:0] dram_rdata,
   output logic [23:0] pm_rdata
);
   // flash word is a fixed scramble of its address
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pm_rdata <= 24'h000000;
      end else if (pm_rd) begin
         pm_rdata <= {pm_addr[22:15] ^ 8'h3C, pm_addr[15:0] ^ 16'hA55A};
      end else begin
         // no strobe: invert, a sample one cycle late sees garbage
         pm_rdata <= ~pm_rdata;
      end
   end
   // ram word likewise, writes are not stored
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dram_rdata <= 16'h0000;
      end else if (dram_req) begin
         dram_rdata <= dram_addr ^ 16'h1E1E;
      end else begin
         dram_rdata <= ~dram_rdata;
      end
   end
endmodule
`default_nettype wire

/* prw_top_bench.sv */
// Purpose: self-checking bench for the program space read window
// Assumes: one access at a time, apb answers without wait states
// Notes: latency counted in edges from the edge that takes a request
`timescale 1ns/10ps
`default_nettype none
module prw_top_bench;
   import prw_pkg::*;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic cpu_req, cpu_we, cpu_is_mov, cpu_busy, cpu_rvalid, cpu_trap;
   logic rpt_active, rpt_first, rpt_last, rpt_int_exit, rpt_reentry;
   logic [15:0] cpu_ea, cpu_wdata, cpu_rdata, dram_addr, dram_wdata, dram_rdata;
   logic dram_req, dram_we, pm_rd;
   logic [22:0] pm_addr;
   logic [23:0] pm_rdata;
   // results of the last cpu access, plus the check tallies
   int lat, n_fail, total_checks;
   logic got_pm, got_dram, got_we, got_trap;
   logic [22:0] seen_addr;
   logic [15:0] rdata, seen_wd, seen_da;
   prw_top u_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_ea(cpu_ea), .cpu_wdata(cpu_wdata),
      .cpu_is_mov(cpu_is_mov), .rpt_active(rpt_active), .rpt_first(rpt_first),
      .rpt_last(rpt_last), .rpt_int_exit(rpt_int_exit), .rpt_reentry(rpt_reentry),
      .cpu_busy(cpu_busy), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_trap(cpu_trap),
      .dram_req(dram_req), .dram_we(dram_we), .dram_addr(dram_addr), .dram_wdata(dram_wdata),
      .dram_rdata(dram_rdata), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .irq(irq));
   prw_mem_model u_mem (.mclk(mclk), .nrst(nrst), .dram_req(dram_req), .dram_addr(dram_addr),
      .pm_rd(pm_rd), .pm_addr(pm_addr), .dram_rdata(dram_rdata), .pm_rdata(pm_rdata));
   // 100 MHz clock
   always #5 mclk = ~mclk;
   // bench copy of the flash content
   function automatic logic [23:0] pm_word(input logic [22:0] a);
      return {a[22:15] ^ 8'h3C, a[15:0] ^ 16'hA55A};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int k;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      // a slave that never answers counts as a mismatch
      if (pready !== 1'b1) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic apb_chk(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk("apb read", exp, r);
      chk("apb error", {31'h0, err_exp}, {31'h0, e});
   endtask
   // one core access; rp = active, first, last, int exit, re-entry
   task automatic cpu(input logic we, input logic [15:0] ea, input logic mov, input logic [4:0] rp);
      @(posedge mclk);
      cpu_req <= 1'b1;
      cpu_we <= we;
      cpu_ea <= ea;
      cpu_wdata <= ~ea;
      cpu_is_mov <= mov;
      {rpt_active, rpt_first, rpt_last, rpt_int_exit, rpt_reentry} <= rp;
      // hold the request until an edge finds the block free
      do begin
         @(posedge mclk);
      end while (cpu_busy === 1'b1);
      cpu_req <= 1'b0;
      {lat, got_pm, got_dram, got_we, got_trap} = '0;
      for (int n = 1; n <= 12; n++) begin
         // pass n looks at what edge n-1 after the taking edge launched
         #1;
         if (pm_rd === 1'b1) begin
            got_pm = 1'b1;
            seen_addr = pm_addr;
         end
         if (dram_req === 1'b1) begin
            got_dram = 1'b1;
            got_we = dram_we;
            seen_wd = dram_wdata;
            seen_da = dram_addr;
         end
         if (cpu_trap === 1'b1) got_trap = 1'b1;
         if (cpu_rvalid === 1'b1) begin
            lat = n;
            rdata = cpu_rdata;
            break;
         end
         @(posedge mclk);
      end
   endtask
   // window read with the expected stall on top of the base three
   task automatic win(input logic [9:0] pg, input logic [15:0] ea, input logic mov,
      input logic [4:0] rp, input int xl);
      logic [22:0] a;
      logic [23:0] w;
      a = {pg[7:0], ea[14:0]};
      w = pm_word(a);
      apb_wr(PRW_OFS_RPAG, {22'h0, pg});
      cpu(1'b0, ea, mov, rp);
      chk("window strobe", 32'h1, {31'h0, got_pm});
      chk("program address", {9'h0, a}, {9'h0, seen_addr});
      chk("read data", pg[8] ? {24'h0, w[23:16]} : {16'h0, w[15:0]}, {16'h0, rdata});
      chk("latency", 32'(3 + xl), 32'(lat));
   endtask
   task automatic t_regs;
      apb_chk(PRW_OFS_RPAG, 32'h1, 1'b0);
      apb_chk(PRW_OFS_WPAG, 32'h1, 1'b0);
      apb_chk(PRW_OFS_STAT, 32'h0, 1'b0);
      apb_chk(PRW_OFS_MASK, 32'h0, 1'b0);
      apb_chk(8'h14, 32'h0, 1'b1);
      $display("test regs done");
   endtask
   task automatic t_window;
      win(10'h202, 16'h800A, 1'b1, 5'h00, 1);
      win(10'h3FF, 16'hFFFF, 1'b0, 5'h00, 2);
      win(10'h2FF, 16'h8000, 1'b1, 5'h00, 1);
      win(10'h300, 16'h8001, 1'b1, 5'h00, 1);
      apb_chk(PRW_OFS_LAST, 32'h0000_0001, 1'b0);
      apb_chk(PRW_OFS_STAT, 32'h2, 1'b0);
      $display("test window done");
   endtask
   task automatic t_plain;
      apb_wr(PRW_OFS_RPAG, 32'h3FF);
      cpu(1'b0, 16'h1234, 1'b0, 5'h00);
      chk("no flash read", 32'h0, {31'h0, got_pm});
      chk("ram data", 32'h0C2A, {16'h0, rdata});
      chk("plain latency", 32'h3, 32'(lat));
      $display("test plain done");
   endtask
   task automatic t_write;
      apb_wr(PRW_OFS_RPAG, 32'h202);
      cpu(1'b1, 16'h9000, 1'b1, 5'h00);
      chk("write skips flash", 32'h0, {31'h0, got_pm});
      chk("write to ram", 32'h1, {31'h0, got_dram & got_we});
      chk("write data", 32'h6FFF, {16'h0, seen_wd});
      chk("write address", 32'h9000, {16'h0, seen_da});
      $display("test write done");
   endtask
   task automatic t_trap;
      apb_wr(PRW_OFS_STAT, 32'h3);
      apb_wr(PRW_OFS_RPAG, 32'h0);
      cpu(1'b0, 16'h8000, 1'b1, 5'h00);
      chk("read trap", 32'h1, {31'h0, got_trap & ~got_pm});
      apb_chk(PRW_OFS_STAT, 32'h1, 1'b0);
      #1 chk("irq masked", 32'h0, {31'h0, irq});
      apb_wr(PRW_OFS_MASK, 32'h1);
      #1 chk("irq raised", 32'h1, {31'h0, irq});
      apb_wr(PRW_OFS_STAT, 32'h1);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
      apb_wr(PRW_OFS_WPAG, 32'h0);
      cpu(1'b1, 16'hC000, 1'b1, 5'h00);
      chk("write trap", 32'h1, {31'h0, got_trap & ~got_dram});
      apb_wr(PRW_OFS_WPAG, 32'h1);
      $display("test trap done");
   endtask
   task automatic t_repeat;
      win(10'h201, 16'h8002, 1'b1, 5'b11000, 2);
      win(10'h201, 16'h8004, 1'b1, 5'b10000, 0);
      win(10'h301, 16'h8006, 1'b0, 5'b10000, 0);
      win(10'h201, 16'h8008, 1'b1, 5'b10100, 2);
      win(10'h201, 16'h800A, 1'b1, 5'b10010, 2);
      win(10'h201, 16'h800C, 1'b1, 5'b10001, 2);
      $display("test repeat done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // watchdog, far beyond the couple of hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      {mclk, nrst, psel, penable, pwrite, cpu_req, cpu_we, cpu_is_mov} = '0;
      {rpt_active, rpt_first, rpt_last, rpt_int_exit, rpt_reentry} = '0;
      {paddr, pwdata, cpu_ea, cpu_wdata} = '0;
      n_fail = 0;
      total_checks = 0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      t_regs();
      t_window();
      t_plain();
      t_write();
      t_trap();
      t_repeat();
      tally_and_finish();
   end
endmodule
`default_nettype wire
